// *** rtl/tisw_input_switch_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module tisw_input_switch_control import tisw_pkg::*; (
	input wire logic pclk, // register clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, high is write
	input wire logic [31:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	output tisw_switch_t switch_ctrl // switch drives, high closes
);

	// one flip-flop per switch, so no switch ever depends on another's logic
	logic calib_b_reg;
	logic drive_direct_reg;
	logic gating_reg;
	logic seventh_reg;
	logic calib_drive_reg;
	logic sense_reg;
	logic input_three_reg;
	logic input_two_reg;
	logic input_one_reg;
	logic input_zero_reg;
	tisw_switch_t switch_state;
	tisw_switch_t switch_next;

	// bus answer flip-flops
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	// bus decode
	logic wait_phase;
	logic access;
	logic hit;
	logic store;
	logic [31:0] wmerged;
	logic [31:0] read_word;

	// pack switch flags at their register positions, every other bit zero
	function automatic logic [31:0] tisw_pack(input tisw_switch_t s);
		logic [31:0] v;
		v = 32'h00000000;
		v[TISW_CALIB_B_BIT] = s.calib_b_to_inverting_switch;
		v[TISW_DRIVE_DIRECT_BIT] = s.drive_direct_switch;
		v[TISW_GATING_BIT] = s.shared_gating_switch;
		v[TISW_SEVENTH_BIT] = s.seventh_routing_switch;
		v[TISW_CALIB_DRIVE_BIT] = s.calib_to_drive_switch;
		v[TISW_SENSE_BIT] = s.sense_route_switch;
		v[TISW_INPUT_THREE_BIT] = s.input_three_route_switch;
		v[TISW_INPUT_TWO_BIT] = s.input_two_route_switch;
		v[TISW_INPUT_ONE_BIT] = s.input_one_route_switch;
		v[TISW_INPUT_ZERO_BIT] = s.input_zero_route_switch;
		return v;
	endfunction

	// inverse of tisw_pack; reserved positions are dropped here and nowhere else,
	// so a write to them can never reach a switch
	function automatic tisw_switch_t tisw_unpack(input logic [31:0] w);
		tisw_switch_t s;
		s = TISW_SWITCH_RESET;
		s.calib_b_to_inverting_switch = w[TISW_CALIB_B_BIT];
		s.drive_direct_switch = w[TISW_DRIVE_DIRECT_BIT];
		s.shared_gating_switch = w[TISW_GATING_BIT];
		s.seventh_routing_switch = w[TISW_SEVENTH_BIT];
		s.calib_to_drive_switch = w[TISW_CALIB_DRIVE_BIT];
		s.sense_route_switch = w[TISW_SENSE_BIT];
		s.input_three_route_switch = w[TISW_INPUT_THREE_BIT];
		s.input_two_route_switch = w[TISW_INPUT_TWO_BIT];
		s.input_one_route_switch = w[TISW_INPUT_ONE_BIT];
		s.input_zero_route_switch = w[TISW_INPUT_ZERO_BIT];
		return s;
	endfunction

	// only the one control word is mapped; every other address answers an error
	function automatic logic tisw_is_mapped(input logic [31:0] addr);
		return (addr == TISW_FULL_CONTROL_ADDR);
	endfunction

	// widen the four byte strobes into a bit mask
	function automatic logic [31:0] tisw_lane_mask(input logic [3:0] strb);
		logic [31:0] mask;
		mask = 32'h00000000;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				mask[i*8 +: 8] = 8'hFF;
			end
		end
		return mask;
	endfunction

	// unstrobed lanes keep the stored image
	function automatic logic [31:0] tisw_merge(input logic [31:0] old_word,
		input logic [31:0] new_word, input logic [3:0] strb);
		logic [31:0] mask;
		mask = tisw_lane_mask(strb);
		return (old_word & ~mask) | (new_word & mask);
	endfunction

	// read data is zero unless a mapped read is answered
	function automatic logic [31:0] tisw_read_value(input logic mapped, input logic write,
		input logic [31:0] word);
		if (mapped && !write) begin
			return word;
		end
		return 32'h00000000;
	endfunction

	// one wait state: the first access cycle raises pready, the second completes
	assign wait_phase = psel && penable && !pready_reg;
	assign access = psel && penable && pready_reg;
	assign hit = tisw_is_mapped(paddr);
	assign store = access && pwrite && hit;
	assign read_word = tisw_pack(switch_state);
	// merging here keeps unstrobed lanes, and so their switches, untouched
	assign wmerged = tisw_merge(read_word, pwdata, pstrb);
	assign switch_next = tisw_unpack(wmerged);

	// reset and hold of the switch image

	// calibration pin b onto the inverting input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			calib_b_reg <= TISW_SWITCH_RESET.calib_b_to_inverting_switch;
		end else begin
			if (store) begin
				calib_b_reg <= switch_next.calib_b_to_inverting_switch;
			end
		end
	end

	// drive electrode straight onto the inverting input
	// no interlock against gating: software owns that pairing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_direct_reg <= TISW_SWITCH_RESET.drive_direct_switch;
		end else begin
			if (store) begin
				drive_direct_reg <= switch_next.drive_direct_switch;
			end
		end
	end

	// shared gate for all the routed inputs
	// closing it with the direct switch still closed is left to software to avoid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gating_reg <= TISW_SWITCH_RESET.shared_gating_switch;
		end else begin
			if (store) begin
				gating_reg <= switch_next.shared_gating_switch;
			end
		end
	end

	// seventh routing switch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seventh_reg <= TISW_SWITCH_RESET.seventh_routing_switch;
		end else begin
			if (store) begin
				seventh_reg <= switch_next.seventh_routing_switch;
			end
		end
	end

	// calibration path onto the drive electrode input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			calib_drive_reg <= TISW_SWITCH_RESET.calib_to_drive_switch;
		end else begin
			if (store) begin
				calib_drive_reg <= switch_next.calib_to_drive_switch;
			end
		end
	end

	// sense electrode through gate and load resistor
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sense_reg <= TISW_SWITCH_RESET.sense_route_switch;
		end else begin
			if (store) begin
				sense_reg <= switch_next.sense_route_switch;
			end
		end
	end

	// analog input three through the gate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_three_reg <= TISW_SWITCH_RESET.input_three_route_switch;
		end else begin
			if (store) begin
				input_three_reg <= switch_next.input_three_route_switch;
			end
		end
	end

	// analog input two through the gate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_two_reg <= TISW_SWITCH_RESET.input_two_route_switch;
		end else begin
			if (store) begin
				input_two_reg <= switch_next.input_two_route_switch;
			end
		end
	end

	// analog input one through the gate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_one_reg <= TISW_SWITCH_RESET.input_one_route_switch;
		end else begin
			if (store) begin
				input_one_reg <= switch_next.input_one_route_switch;
			end
		end
	end

	// analog input zero through the gate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_zero_reg <= TISW_SWITCH_RESET.input_zero_route_switch;
		end else begin
			if (store) begin
				input_zero_reg <= switch_next.input_zero_route_switch;
			end
		end
	end

	// gather the switch flip-flops into the carrier struct
	always_comb begin
		switch_state = TISW_SWITCH_RESET;
		switch_state.calib_b_to_inverting_switch = calib_b_reg;
		switch_state.drive_direct_switch = drive_direct_reg;
		switch_state.shared_gating_switch = gating_reg;
		switch_state.seventh_routing_switch = seventh_reg;
		switch_state.calib_to_drive_switch = calib_drive_reg;
		switch_state.sense_route_switch = sense_reg;
		switch_state.input_three_route_switch = input_three_reg;
		switch_state.input_two_route_switch = input_two_reg;
		switch_state.input_one_route_switch = input_one_reg;
		switch_state.input_zero_route_switch = input_zero_reg;
	end

	// answer path

	// pready: high for exactly the one cycle that completes a transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= wait_phase;
		end
	end

	// pslverr: flags an unmapped address, only alongside pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_reg <= 1'b0;
		end else if (wait_phase) begin
			pslverr_reg <= !hit;
		end else begin
			pslverr_reg <= 1'b0;
		end
	end

	// prdata: zero outside the answer cycle, so stale switch state never leaks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
		end else if (wait_phase) begin
			prdata_reg <= tisw_read_value(hit, pwrite, read_word);
		end else begin
			prdata_reg <= 32'h00000000;
		end
	end

	// every output is a flip-flop or a bundle of them
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign switch_ctrl = switch_state;

endmodule
`default_nettype wire

// *** rtl/tisw_pkg.sv ***
package tisw_pkg;

	localparam logic [31:0] TISW_FULL_CONTROL_ADDR = 32'h0000215C;
	localparam logic [31:0] TISW_FULL_CONTROL_RESET = 32'h00000000;

	localparam int TISW_CALIB_B_BIT = 11;
	localparam int TISW_DRIVE_DIRECT_BIT = 9;
	localparam int TISW_GATING_BIT = 8;
	localparam int TISW_SEVENTH_BIT = 6;
	localparam int TISW_CALIB_DRIVE_BIT = 5;
	localparam int TISW_SENSE_BIT = 4;
	localparam int TISW_INPUT_THREE_BIT = 3;
	localparam int TISW_INPUT_TWO_BIT = 2;
	localparam int TISW_INPUT_ONE_BIT = 1;
	localparam int TISW_INPUT_ZERO_BIT = 0;

	// one flag per analog switch, high means closed
	typedef struct packed {
		logic calib_b_to_inverting_switch;
		logic drive_direct_switch;
		logic shared_gating_switch;
		logic seventh_routing_switch;
		logic calib_to_drive_switch;
		logic sense_route_switch;
		logic input_three_route_switch;
		logic input_two_route_switch;
		logic input_one_route_switch;
		logic input_zero_route_switch;
	} tisw_switch_t;

	localparam tisw_switch_t TISW_SWITCH_RESET = '0;

endpackage

// *** rtl/tisw_dummy_unused.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/tisw_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module tisw_asserts import tisw_pkg::*; (
	input wire logic pclk, // register clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [31:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	input wire logic [31:0] prdata, // apb read data
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire tisw_switch_t switch_ctrl // switch drives
);
	wire logic hit = paddr == TISW_FULL_CONTROL_ADDR;
	wire logic wr = psel && penable && pready && pwrite && hit;
	wire logic [31:0] rv = {20'h0, switch_ctrl[9], 1'b0, switch_ctrl[8:7], 1'b0, switch_ctrl[6:0]};
	wire logic [31:0] msk = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire logic [31:0] mw = (rv & ~msk) | (pwdata & msk);
	wire logic [9:0] wv = {mw[11], mw[9:8], mw[6:0]};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_one_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("wait");
	a_rdy_pulse: assert property (pready |=> !pready) else $error("pulse");
	a_wr_store: assert property (wr |=> switch_ctrl == $past(wv)) else $error("store");
	a_ctrl_hold: assert property (!wr |=> $stable(switch_ctrl)) else $error("hold");
	a_rd_back: assert property (pready && !pwrite && hit |-> prdata == rv) else $error("read");
	a_bad_addr: assert property (pready && !hit |-> pslverr && prdata == 32'h0) else $error("err");
	a_idle_zero: assert property (!pready |-> !pslverr && prdata == 32'h0) else $error("idle");
	a_good_addr: assert property (pready && hit |-> !pslverr) else $error("ok");
	a_resv_zero: assert property (pready |-> prdata[31:12] == 20'h0 && !prdata[10] && !prdata[7])
		else $error("reserved");
endmodule
bind tisw_input_switch_control tisw_asserts i_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .switch_ctrl(switch_ctrl));
`default_nettype wire

// *** tb/test_tia_input_switch_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_tia_input_switch_control import tisw_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [31:0] paddr = 0, pwdata = 0, m = 0, prdata, d;
	logic [3:0] pstrb = 4'h0, s;
	tisw_switch_t switch_ctrl;
	logic [42:0] q[$], n;
	int err_count = 0, tests_run = 0;
	localparam logic [31:0] A = TISW_FULL_CONTROL_ADDR;
	always #5 pclk = ~pclk;
	tisw_input_switch_control i_dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .switch_ctrl);
	function automatic logic [31:0] lanes(input logic [3:0] x);
		return {{8{x[3]}}, {8{x[2]}}, {8{x[1]}}, {8{x[0]}}};
	endfunction
	task automatic print_verdict(input int extra);
		err_count += extra;
		if (q.size() != 0) err_count++;
		$display("runs %0d errs %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// reads note the expected image; writes only show through later reads
	task automatic apb(input logic [31:0] a, input logic [31:0] dat, input logic [3:0] st,
		input logic w);
		@(posedge pclk) {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, dat, w ? st : 4'h0};
		if (!w) q.push_back({a != A, m[11], m[9:8], m[6:0], a == A ? m : 32'h0});
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (!pready);
		{psel, penable} <= 2'b0;
		if (w && a == A) m = ((m & ~lanes(st)) | (dat & lanes(st))) & 32'hB7F;
	endtask
	always @(posedge pclk) if (pready && !pwrite) begin
		n = q.pop_front();
		tests_run++;
		if (n !== {pslverr, switch_ctrl, prdata}) begin
			err_count++;
			$display("MISMATCH %0t exp=%h got=%h", $time, n, {pslverr, switch_ctrl, prdata});
		end
	end
	// the tests need about 370 cycles; this allows over twenty-five times that
	initial #100000 print_verdict(1);
	initial begin
		void'($urandom(32'h252B));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 44; i++) begin
			d = i < 32 ? 32'h1 << i : $urandom;
			s = i < 36 ? 4'hF : 4'($urandom);
			if (d[TISW_GATING_BIT]) d[TISW_DRIVE_DIRECT_BIT] = 1'b0;
			apb(i == 40 ? A + 32'h4 : A, d, s, 1'b1);
			apb(i == 41 ? A + 32'h4 : A, 32'h0, 4'h0, 1'b0);
			$display("test %0d done", i);
		end
		@(posedge pclk) presetn <= 1'b0;
		m = 32'h0;
		@(posedge pclk) presetn <= 1'b1;
		apb(A, 32'h0, 4'h0, 1'b0);
		@(posedge pclk);
		print_verdict(0);
	end
endmodule
`default_nettype wire
